//--- rtl/cfps_pkg.sv
package cfps_pkg;
  // Register offsets on the register port
  localparam logic [7:0] CFPS_ADDR_CF_CTRL   = 8'h2c;
  localparam logic [7:0] CFPS_ADDR_CF2_TIME  = 8'h2e;
  localparam logic [7:0] CFPS_ADDR_PCM_RATE  = 8'h2f;
  localparam logic [7:0] CFPS_ADDR_RECOVERY  = 8'h32;
  localparam logic [7:0] CFPS_ADDR_OVERRIDE  = 8'h35;
  localparam logic [7:0] CFPS_ADDR_POWER     = 8'h64;
  localparam logic [7:0] CFPS_ADDR_BOOT      = 8'h65;
  localparam logic [7:0] CFPS_ADDR_STICKY1   = 8'h68;
  localparam logic [7:0] CFPS_ADDR_STICKY2   = 8'h6c;
  // Reset values
  localparam logic [7:0] CFPS_RST_REG        = 8'h00;
  // Field positions
  localparam int CFPS_CF2_EN_BIT      = 0;
  localparam int CFPS_CF2_SEL_LSB     = 2;
  localparam int CFPS_CF2_RATE_LSB    = 6;
  localparam int CFPS_CF2_TO_LSB      = 0;
  localparam int CFPS_PCM_RATE_LSB    = 0;
  localparam int CFPS_REC_F2_BIT      = 1;
  localparam int CFPS_REC_F1_BIT      = 0;
  localparam int CFPS_OVR_KILL_BIT    = 2;
  localparam int CFPS_OVR_I2V_BIT     = 1;
  localparam int CFPS_OVR_CLAMP_BIT   = 0;
  localparam int CFPS_POW_STAT_LSB    = 2;
  localparam int CFPS_BOOT_BIT        = 2;
  localparam int CFPS_ST2_CLK1_BIT    = 3;
  localparam int CFPS_ST2_CLK2_BIT    = 2;
  // Clock-select code that is reserved
  localparam logic [1:0] CFPS_SEL_RSVD = 2'h3;
  // Timing: clock rate and printed times
  localparam int unsigned CFPS_CLK_MHZ = 50;
  localparam int unsigned CFPS_TIMEOUT_US [8] =
    '{2730, 22000, 44000, 87000, 174000, 350000, 700000, 1400000};
  localparam int unsigned CFPS_RAMP_US_PER_DB [4] = '{15, 30, 60, 120};
  localparam int unsigned CFPS_TIMEOUT_CYC [8] = '{
    CFPS_TIMEOUT_US[0] * CFPS_CLK_MHZ, CFPS_TIMEOUT_US[1] * CFPS_CLK_MHZ,
    CFPS_TIMEOUT_US[2] * CFPS_CLK_MHZ, CFPS_TIMEOUT_US[3] * CFPS_CLK_MHZ,
    CFPS_TIMEOUT_US[4] * CFPS_CLK_MHZ, CFPS_TIMEOUT_US[5] * CFPS_CLK_MHZ,
    CFPS_TIMEOUT_US[6] * CFPS_CLK_MHZ, CFPS_TIMEOUT_US[7] * CFPS_CLK_MHZ};
  localparam int unsigned CFPS_RAMP_CYC [4] = '{
    CFPS_RAMP_US_PER_DB[0] * CFPS_CLK_MHZ, CFPS_RAMP_US_PER_DB[1] * CFPS_CLK_MHZ,
    CFPS_RAMP_US_PER_DB[2] * CFPS_CLK_MHZ, CFPS_RAMP_US_PER_DB[3] * CFPS_CLK_MHZ};
  // Attenuation at which the ramp counts as finished
  localparam logic [7:0] CFPS_ATTEN_MAX = 8'h7f;
  // Detector 2 states
  typedef enum logic [1:0] {
    CFPS_MON  = 2'b00,
    CFPS_RAMP = 2'b01,
    CFPS_HALT = 2'b10
  } cfps_det_state_t;
endpackage

//--- rtl/cfps_det_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cfps_det_if;
  logic       enable;
  logic [1:0] clock_sel;
  logic [2:0] timeout_sel;
  logic [1:0] ramp_rate;
  logic       recovery_inhibit;
  logic       fault;
  logic       fault_pulse;
  logic       ramp_step;
  logic [7:0] atten;
  modport regs (output enable, clock_sel, timeout_sel, ramp_rate, recovery_inhibit,
                input fault, fault_pulse, ramp_step, atten);
  modport det  (input enable, clock_sel, timeout_sel, ramp_rate, recovery_inhibit,
                output fault, fault_pulse, ramp_step, atten);
endinterface
`default_nettype wire

//--- rtl/cfps_clk_det.sv
`timescale 1ns/1ps
`default_nettype none
module cfps_clk_det
  import cfps_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC [8] = CFPS_TIMEOUT_CYC,
  parameter int unsigned RAMP_CYC [4]    = CFPS_RAMP_CYC
) (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic [2:0] mon_clk,
  cfps_det_if.det         dif
);
  logic [2:0]      sync1, sync2, sync3;
  logic [26:0]     idle_cnt, next_idle_cnt;
  logic [12:0]     ramp_cnt, next_ramp_cnt;
  logic [7:0]      atten, next_atten;
  logic            step, next_step, fpulse, next_fpulse;
  cfps_det_state_t state, next_state;
  logic            active, edge_seen;
  logic [31:0]     idle_lim, ramp_lim;

  // Monitored clocks are foreign: three stages, an edge counts once stages two and three differ
  always_ff @(posedge mclk) begin
    if (reset) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      sync3 <= 3'h0;
    end else begin
      sync1 <= mon_clk;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Reserved select watches nothing, so the detector idles rather than false-tripping
  assign active    = dif.enable && (dif.clock_sel != CFPS_SEL_RSVD);
  assign edge_seen = active && (sync2[dif.clock_sel] ^ sync3[dif.clock_sel]);
  assign idle_lim  = TIMEOUT_CYC[dif.timeout_sel] - 32'd1;
  assign ramp_lim  = RAMP_CYC[dif.ramp_rate] - 32'd1;

  // Timeout watch, gain ramp and recovery
  always_comb begin
    next_state    = state;
    next_idle_cnt = idle_cnt;
    next_ramp_cnt = ramp_cnt;
    next_atten    = atten;
    next_step     = 1'b0;
    next_fpulse   = 1'b0;
    if (!active) begin
      next_state    = CFPS_MON;
      next_idle_cnt = 27'h0;
      next_atten    = 8'h00;
    end else begin
      unique case (state)
        CFPS_MON: begin
          if (edge_seen) begin
            next_idle_cnt = 27'h0;
          end else if ({5'h0, idle_cnt} >= idle_lim) begin
            next_state    = CFPS_RAMP;
            next_fpulse   = 1'b1;
            next_idle_cnt = 27'h0;
            next_ramp_cnt = 13'h0;
          end else begin
            next_idle_cnt = idle_cnt + 27'h1;
          end
        end
        CFPS_RAMP: begin
          if (edge_seen && !dif.recovery_inhibit) begin
            next_state = CFPS_MON;
            next_atten = 8'h00;
          end else if ({19'h0, ramp_cnt} >= ramp_lim) begin
            next_ramp_cnt = 13'h0;
            next_step     = 1'b1;
            next_atten    = atten + 8'h01;
            if (atten + 8'h01 == CFPS_ATTEN_MAX) begin
              next_state = CFPS_HALT;
            end
          end else begin
            next_ramp_cnt = ramp_cnt + 13'h1;
          end
        end
        CFPS_HALT: begin
          // Inhibited recovery holds here until the detector is disabled
          if (edge_seen && !dif.recovery_inhibit) begin
            next_state = CFPS_MON;
            next_atten = 8'h00;
          end
        end
        default: next_state = CFPS_MON;
      endcase
    end
  end

  // Detector state registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      state    <= CFPS_MON;
      idle_cnt <= 27'h0;
      ramp_cnt <= 13'h0;
      atten    <= 8'h00;
      step     <= 1'b0;
      fpulse   <= 1'b0;
    end else begin
      state    <= next_state;
      idle_cnt <= next_idle_cnt;
      ramp_cnt <= next_ramp_cnt;
      atten    <= next_atten;
      step     <= next_step;
      fpulse   <= next_fpulse;
    end
  end

  assign dif.fault       = (state != CFPS_MON);
  assign dif.fault_pulse = fpulse;
  assign dif.ramp_step   = step;
  assign dif.atten       = atten;
endmodule
`default_nettype wire

//--- rtl/cfps_regs.sv
`timescale 1ns/1ps
`default_nettype none
module cfps_regs
  import cfps_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC [8] = CFPS_TIMEOUT_CYC,
  parameter int unsigned RAMP_CYC [4]    = CFPS_RAMP_CYC
) (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       mon_clk_dac,
  input  wire logic       mon_clk_adc,
  input  wire logic       mon_clk_pll,
  input  wire logic       fault1_event,
  input  wire logic       fault1_clock_ok,
  input  wire logic       dac_up_pin,
  input  wire logic       output_stage_up_pin,
  input  wire logic       booster_up_pin,
  input  wire logic       booster_passthru_pin,
  input  wire logic       current_sense_up_pin,
  input  wire logic       voltage_sense_up_pin,
  input  wire logic       boot_busy_pin,
  input  wire logic       over_current_evt,
  input  wire logic       under_voltage_evt,
  input  wire logic       over_temp_evt,
  input  wire logic       brownout_evt,
  input  wire logic       clock_lost_evt,
  input  wire logic       sar_done_evt,
  output logic            power_fault_signal,
  output logic            fault2_ramp_step,
  output logic      [7:0] fault2_gain_atten,
  output logic      [1:0] pcm_rate_sel,
  output logic            provisional_powerup_kill,
  output logic            current_conv_startup_test,
  output logic            integrator_clamp_ctl
);
  localparam int NSTAT = 7;

  cfps_det_if det_bus();

  // Writable registers, held whole so reserved bits read back what was written
  logic [7:0] cf_ctrl, next_cf_ctrl;
  logic [7:0] clock_fault2_timing, next_clock_fault2_timing;
  logic [7:0] pcm_rate_select, next_pcm_rate_select;
  logic [7:0] clock_fault_recovery, next_clock_fault_recovery;
  logic [7:0] test_override_ctrl, next_test_override_ctrl;
  logic [1:0] power_rsvd, next_power_rsvd;
  logic       sticky1_rsvd, next_sticky1_rsvd;
  // Sticky fault flags
  logic [7:0] fault_source_sticky_1, next_fault_source_sticky_1;
  logic [7:0] fault_source_sticky_2, next_fault_source_sticky_2;
  logic [7:0] evt1_vec, evt2_vec;
  // Detector 1 hold and shared fault output
  logic       fault1_halt, next_fault1_halt;
  logic       next_power_fault;
  logic [7:0] next_rdata;
  logic [7:0] block_power_state, processor_boot_state;
  // Status pin synchronisers
  logic [NSTAT-1:0] stat_pins, stat_s1, stat_s2, stat_s3, stat_filt, next_stat_filt;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction

  // Write path
  always_comb begin
    next_cf_ctrl              = cf_ctrl;
    next_clock_fault2_timing  = clock_fault2_timing;
    next_pcm_rate_select      = pcm_rate_select;
    next_clock_fault_recovery = clock_fault_recovery;
    next_test_override_ctrl   = test_override_ctrl;
    next_power_rsvd           = power_rsvd;
    next_sticky1_rsvd         = sticky1_rsvd;
    if (reg_wr) begin
      if (hit(reg_addr, CFPS_ADDR_CF_CTRL)) begin
        next_cf_ctrl = reg_wdata;
      end
      if (hit(reg_addr, CFPS_ADDR_CF2_TIME)) begin
        next_clock_fault2_timing = reg_wdata;
      end
      if (hit(reg_addr, CFPS_ADDR_PCM_RATE)) begin
        next_pcm_rate_select = reg_wdata;
      end
      if (hit(reg_addr, CFPS_ADDR_RECOVERY)) begin
        next_clock_fault_recovery = reg_wdata;
      end
      if (hit(reg_addr, CFPS_ADDR_OVERRIDE)) begin
        next_test_override_ctrl = reg_wdata;
      end
      if (hit(reg_addr, CFPS_ADDR_POWER)) begin
        next_power_rsvd = reg_wdata[1:0];
      end
      if (hit(reg_addr, CFPS_ADDR_STICKY1)) begin
        next_sticky1_rsvd = reg_wdata[0];
      end
    end
  end

  // Control registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      cf_ctrl              <= CFPS_RST_REG;
      clock_fault2_timing  <= CFPS_RST_REG;
      pcm_rate_select      <= CFPS_RST_REG;
      clock_fault_recovery <= CFPS_RST_REG;
      test_override_ctrl   <= CFPS_RST_REG;
      power_rsvd           <= 2'h0;
      sticky1_rsvd         <= 1'b0;
    end else begin
      cf_ctrl              <= next_cf_ctrl;
      clock_fault2_timing  <= next_clock_fault2_timing;
      pcm_rate_select      <= next_pcm_rate_select;
      clock_fault_recovery <= next_clock_fault_recovery;
      test_override_ctrl   <= next_test_override_ctrl;
      power_rsvd           <= next_power_rsvd;
      sticky1_rsvd         <= next_sticky1_rsvd;
    end
  end

  // Detector 2 setup from the control fields
  assign det_bus.enable           = cf_ctrl[CFPS_CF2_EN_BIT];
  assign det_bus.clock_sel        = cf_ctrl[CFPS_CF2_SEL_LSB +: 2];
  assign det_bus.timeout_sel      = clock_fault2_timing[CFPS_CF2_TO_LSB +: 3];
  assign det_bus.ramp_rate        = clock_fault2_timing[CFPS_CF2_RATE_LSB +: 2];
  assign det_bus.recovery_inhibit = clock_fault_recovery[CFPS_REC_F2_BIT];

  cfps_clk_det #(
    .TIMEOUT_CYC (TIMEOUT_CYC),
    .RAMP_CYC    (RAMP_CYC)
  ) u_det2 (
    .mclk    (mclk),
    .reset   (reset),
    .mon_clk ({mon_clk_pll, mon_clk_adc, mon_clk_dac}),
    .dif     (det_bus)
  );

  // Status pins come from analog and boot logic: three stages, accept when two and three agree
  assign stat_pins = {boot_busy_pin, dac_up_pin, output_stage_up_pin, booster_up_pin,
                      booster_passthru_pin, current_sense_up_pin, voltage_sense_up_pin};

  always_comb begin
    next_stat_filt = (stat_s2 ~^ stat_s3) & stat_s3 | (stat_s2 ^ stat_s3) & stat_filt;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      stat_s1   <= '0;
      stat_s2   <= '0;
      stat_s3   <= '0;
      stat_filt <= '0;
    end else begin
      stat_s1   <= stat_pins;
      stat_s2   <= stat_s1;
      stat_s3   <= stat_s2;
      stat_filt <= next_stat_filt;
    end
  end

  // Power status: DAC, output stage, boost, pass-through, current and voltage sense
  assign block_power_state = {stat_filt[5], stat_filt[4], stat_filt[3],
                              stat_filt[2],
                              stat_filt[1], stat_filt[0],
                              power_rsvd};
  // Boot status: 1 while booting; host must hold off coefficient writes until 0
  assign processor_boot_state = {5'h00, stat_filt[6], 2'h0};

  // Event vectors; unused positions stay zero
  assign evt1_vec = {over_current_evt, under_voltage_evt, 1'b0, over_temp_evt,
                     brownout_evt, clock_lost_evt, sar_done_evt, 1'b0};
  assign evt2_vec = {4'h0, fault1_event, det_bus.fault_pulse, 2'h0};

  // Sticky flags: a read clears the register, but an event in that cycle survives
  always_comb begin
    next_fault_source_sticky_1 = fault_source_sticky_1 | evt1_vec;
    next_fault_source_sticky_2 = fault_source_sticky_2 | evt2_vec;
    if (reg_rd && hit(reg_addr, CFPS_ADDR_STICKY1)) begin
      next_fault_source_sticky_1 = evt1_vec;
    end
    if (reg_rd && hit(reg_addr, CFPS_ADDR_STICKY2)) begin
      next_fault_source_sticky_2 = evt2_vec;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      fault_source_sticky_1 <= CFPS_RST_REG;
      fault_source_sticky_2 <= CFPS_RST_REG;
    end else begin
      fault_source_sticky_1 <= next_fault_source_sticky_1;
      fault_source_sticky_2 <= next_fault_source_sticky_2;
    end
  end

  // Detector 1 hold: a new fault wins over a recovery in the same cycle
  always_comb begin
    next_fault1_halt = fault1_halt;
    if (fault1_event) begin
      next_fault1_halt = 1'b1;
    end else if (fault1_clock_ok && !clock_fault_recovery[CFPS_REC_F1_BIT]) begin
      next_fault1_halt = 1'b0;
    end
    next_power_fault = fault1_halt || det_bus.fault;
  end

  // Read mux, answered one cycle after the read strobe
  always_comb begin
    next_rdata = reg_rdata;
    if (reg_rd) begin
      next_rdata = 8'h00;
      if (hit(reg_addr, CFPS_ADDR_CF_CTRL)) begin
        next_rdata = cf_ctrl;
      end
      if (hit(reg_addr, CFPS_ADDR_CF2_TIME)) begin
        next_rdata = clock_fault2_timing;
      end
      if (hit(reg_addr, CFPS_ADDR_PCM_RATE)) begin
        next_rdata = pcm_rate_select;
      end
      if (hit(reg_addr, CFPS_ADDR_RECOVERY)) begin
        next_rdata = clock_fault_recovery;
      end
      if (hit(reg_addr, CFPS_ADDR_OVERRIDE)) begin
        next_rdata = test_override_ctrl;
      end
      if (hit(reg_addr, CFPS_ADDR_POWER)) begin
        next_rdata = block_power_state;
      end
      if (hit(reg_addr, CFPS_ADDR_BOOT)) begin
        next_rdata = processor_boot_state;
      end
      if (hit(reg_addr, CFPS_ADDR_STICKY1)) begin
        next_rdata = {fault_source_sticky_1[7:1], sticky1_rsvd};
      end
      if (hit(reg_addr, CFPS_ADDR_STICKY2)) begin
        next_rdata = fault_source_sticky_2;
      end
    end
  end

  // Output and read-data registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      fault1_halt               <= 1'b0;
      power_fault_signal        <= 1'b0;
      reg_rdata                 <= 8'h00;
      fault2_ramp_step          <= 1'b0;
      fault2_gain_atten         <= 8'h00;
      pcm_rate_sel              <= 2'h0;
      provisional_powerup_kill  <= 1'b0;
      current_conv_startup_test <= 1'b0;
      integrator_clamp_ctl      <= 1'b0;
    end else begin
      fault1_halt               <= next_fault1_halt;
      power_fault_signal        <= next_power_fault;
      reg_rdata                 <= next_rdata;
      fault2_ramp_step          <= det_bus.ramp_step;
      fault2_gain_atten         <= det_bus.atten;
      pcm_rate_sel              <= pcm_rate_select[CFPS_PCM_RATE_LSB +: 2];
      provisional_powerup_kill  <= test_override_ctrl[CFPS_OVR_KILL_BIT];
      current_conv_startup_test <= test_override_ctrl[CFPS_OVR_I2V_BIT];
      integrator_clamp_ctl      <= test_override_ctrl[CFPS_OVR_CLAMP_BIT];
    end
  end
endmodule
`default_nettype wire

//--- tb/cfps_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module cfps_regs_monitor
  import cfps_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC [8] = CFPS_TIMEOUT_CYC,
  parameter int unsigned RAMP_CYC [4]    = CFPS_RAMP_CYC
) (
  input wire logic       mclk,
  input wire logic       reset,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       dac_up_pin,
  input wire logic       output_stage_up_pin,
  input wire logic       booster_up_pin,
  input wire logic       booster_passthru_pin,
  input wire logic       current_sense_up_pin,
  input wire logic       voltage_sense_up_pin,
  input wire logic       boot_busy_pin,
  input wire logic       over_current_evt,
  input wire logic       power_fault_signal,
  input wire logic       fault2_ramp_step,
  input wire logic [7:0] fault2_gain_atten,
  input wire logic [1:0] pcm_rate_sel,
  input wire logic       provisional_powerup_kill
);
  wire logic [5:0] pw = {dac_up_pin, output_stage_up_pin, booster_up_pin,
                         booster_passthru_pin, current_sense_up_pin, voltage_sense_up_pin};
  logic [1:0] rate, next_rate;
  logic [9:0] gap, next_gap;
  logic       seen, next_seen;

  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  // Rate shadow and step spacing; the first step of a ramp has no reference
  always_comb begin
    next_rate = rate;
    if (reg_wr && reg_addr == CFPS_ADDR_CF2_TIME) next_rate = reg_wdata[7:6];
    next_gap = fault2_ramp_step ? 10'h000 : gap + 10'h001;
    next_seen = power_fault_signal && (seen || fault2_ramp_step);
  end
  always_ff @(posedge mclk) begin
    rate <= reset ? 2'h0 : next_rate;
    gap <= reset ? 10'h000 : next_gap;
    seen <= reset ? 1'b0 : next_seen;
  end

  sequence s_rd68;
    reg_rd && reg_addr == CFPS_ADDR_STICKY1;
  endsequence
  sequence s_pins_still;
    $stable(pw) [*6];
  endsequence
  property p_rate;
    logic [1:0] d;
    (reg_wr && reg_addr == CFPS_ADDR_PCM_RATE, d = reg_wdata[1:0]) |-> ##2 pcm_rate_sel == d;
  endproperty
  property p_kill;
    logic k;
    (reg_wr && reg_addr == CFPS_ADDR_OVERRIDE, k = reg_wdata[2])
      |-> ##2 provisional_powerup_kill == k;
  endproperty
  property p_stky;
    over_current_evt ##1 s_rd68 |=> reg_rdata[7];
  endproperty
  property p_clr;
    (s_rd68 ##0 !over_current_evt) ##1 s_rd68 |=> !reg_rdata[7];
  endproperty
  property p_pow;
    logic [5:0] p;
    (s_pins_still ##0 (reg_rd && reg_addr == CFPS_ADDR_POWER, p = pw)) |=> reg_rdata[7:2] == p;
  endproperty
  property p_boot;
    ($stable(boot_busy_pin) [*6] ##0 reg_rd && reg_addr == CFPS_ADDR_BOOT)
      |=> reg_rdata == {5'h00, $past(boot_busy_pin), 2'h0};
  endproperty
  property p_atten;
    fault2_gain_atten != 8'h00 |-> power_fault_signal;
  endproperty
  property p_step;
    fault2_ramp_step && seen |-> gap == 10'(RAMP_CYC[rate] - 1);
  endproperty
  a_rate: assert property (p_rate) else $error("pcm rate output wrong");
  a_kill: assert property (p_kill) else $error("override output wrong");
  a_stky: assert property (p_stky) else $error("sticky flag lost");
  a_clr: assert property (p_clr) else $error("sticky flag not cleared");
  a_pow: assert property (p_pow) else $error("power status wrong");
  a_boot: assert property (p_boot) else $error("boot status wrong");
  a_atten: assert property (p_atten) else $error("ramp without shutdown");
  a_step: assert property (p_step) else $error("ramp step spacing wrong");
endmodule

bind cfps_regs cfps_regs_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC), .RAMP_CYC(RAMP_CYC)) i_mon (
  .mclk, .reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .dac_up_pin,
  .output_stage_up_pin, .booster_up_pin, .booster_passthru_pin, .current_sense_up_pin,
  .voltage_sense_up_pin, .boot_busy_pin, .over_current_evt, .power_fault_signal,
  .fault2_ramp_step, .fault2_gain_atten, .pcm_rate_sel, .provisional_powerup_kill
);
`default_nettype wire

//--- tb/tb_clock_fault_and_power_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_clock_fault_and_power_status_regs import cfps_pkg::*; ();
  typedef struct {logic [7:0] a, d, e;} cfps_row_t;
  logic       mclk, reset, reg_wr, reg_rd, fault1_event, fault1_clock_ok, boot_busy_pin;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, fault2_gain_atten;
  logic [5:0] pins, evt;
  logic [2:0] mon = 3'h0, run;
  logic [1:0] div = 2'h0, pcm_rate_sel;
  logic [7:0] a0;
  logic       power_fault_signal, fault2_ramp_step, provisional_powerup_kill;
  logic       current_conv_startup_test, integrator_clamp_ctl;
  int         n_fail = 0, n_checks = 0, cyc = 0, n;
  // Address, written value, read-back; status and sticky bits refuse writes
  cfps_row_t  rows [10] = '{'{8'h2e, 8'hff, 8'hff}, '{8'h2f, 8'hfc, 8'hfc},
    '{8'h32, 8'hfc, 8'hfc}, '{8'h35, 8'hf8, 8'hf8}, '{8'h2c, 8'hf2, 8'hf2},
    '{8'h64, 8'hff, 8'h03}, '{8'h65, 8'hff, 8'h00}, '{8'h68, 8'hff, 8'h01},
    '{8'h6c, 8'hff, 8'h00}, '{8'h40, 8'hff, 8'h00}};

  cfps_regs #(.TIMEOUT_CYC('{40, 50, 60, 70, 80, 90, 100, 110}), .RAMP_CYC('{3, 4, 5, 6})) i_dut (
    .mclk, .reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .mon_clk_dac(mon[0]), .mon_clk_adc(mon[1]), .mon_clk_pll(mon[2]),
    .fault1_event, .fault1_clock_ok, .dac_up_pin(pins[5]), .output_stage_up_pin(pins[4]),
    .booster_up_pin(pins[3]), .booster_passthru_pin(pins[2]), .current_sense_up_pin(pins[1]),
    .voltage_sense_up_pin(pins[0]), .boot_busy_pin, .over_current_evt(evt[5]),
    .under_voltage_evt(evt[4]), .over_temp_evt(evt[3]), .brownout_evt(evt[2]),
    .clock_lost_evt(evt[1]), .sar_done_evt(evt[0]), .power_fault_signal, .fault2_ramp_step,
    .fault2_gain_atten, .pcm_rate_sel, .provisional_powerup_kill, .current_conv_startup_test,
    .integrator_clamp_ctl
  );

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Watched clocks toggle every fourth edge; a stopped one stands still
  always @(posedge mclk) begin
    div <= div + 2'h1;
    if (div == 2'h3) mon <= mon ^ run;
  end
  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkf(input logic e);
    chk("power_fault_signal", {7'h0, e}, {7'h0, power_fault_signal});
  endtask
  // Strobes drop for one edge after each access, so calls can follow directly
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    tick(1);
    reg_wr <= 1'b0;
    tick(1);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    tick(1);
    reg_rd <= 1'b0;
    tick(1);
    chk($sformatf("reg %h", a), e, reg_rdata);
  endtask
  task automatic wrap_up();
    if (n_fail == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    reset = 1'b1;
    {reg_wr, reg_rd, fault1_event, fault1_clock_ok, boot_busy_pin} = 5'h00;
    {reg_addr, reg_wdata, pins, evt} = 28'h0;
    run = 3'h7;
    tick(10);
    reset <= 1'b0;
    tick(1);
    foreach (rows[i]) rdchk(rows[i].a, 8'h00);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rdchk(rows[i].a, rows[i].e);
    end
    for (int i = 0; i < 4; i++) begin
      wr(CFPS_ADDR_PCM_RATE, 8'(i));
      tick(1);
      chk("pcm_rate_sel", 8'(i), {6'h0, pcm_rate_sel});
    end
    for (int i = 0; i < 2; i++) begin
      wr(CFPS_ADDR_OVERRIDE, i ? 8'h03 : 8'h07);
      tick(1);
      chk("override", i ? 8'h03 : 8'h07, {5'h0, provisional_powerup_kill,
          current_conv_startup_test, integrator_clamp_ctl});
    end
    for (int i = 0; i < 2; i++) begin
      pins <= i ? 6'h12 : 6'h2d;
      boot_busy_pin <= (i == 0);
      tick(8);
      rdchk(CFPS_ADDR_POWER, {i ? 6'h12 : 6'h2d, 2'h3});
      rdchk(CFPS_ADDR_BOOT, i ? 8'h00 : 8'h04);
    end
    for (int i = 0; i < 6; i++) begin
      evt <= 6'h01 << i;
      tick(1);
      evt <= 6'h00;
      rdchk(CFPS_ADDR_STICKY1, 8'(8'h01 | (8'h01 << (i + 1 + (i >= 4)))));
      rdchk(CFPS_ADDR_STICKY1, 8'h01);
    end
    // Three back-to-back reads, an event landing on the first one
    reg_addr <= CFPS_ADDR_STICKY1;
    reg_rd <= 1'b1;
    evt <= 6'h20;
    tick(1);
    evt <= 6'h00;
    // Read data is looked at just after each edge, once it has settled
    #1 chk("sticky", 8'h01, reg_rdata);
    tick(1);
    #1 chk("sticky", 8'h81, reg_rdata);
    tick(1);
    reg_rd <= 1'b0;
    #1 chk("sticky", 8'h01, reg_rdata);
    tick(1);
    // Every timeout code, non-reserved clock select and ramp rate: quiet, fault, ramp, recovery
    for (int c = 0; c < 8; c++) begin
      run <= 3'h1 << (c % 3);
      wr(CFPS_ADDR_CF2_TIME, 8'(((c % 4) << 6) | c));
      wr(CFPS_ADDR_CF_CTRL, 8'(((c % 3) << 2) | 1));
      tick(40);
      chkf(1'b0);
      run <= 3'h0;
      tick(28 + 10 * c);
      chkf(1'b0);
      tick(30);
      chkf(1'b1);
      n = 0;
      a0 = fault2_gain_atten;
      repeat (60) begin
        tick(1);
        if (fault2_ramp_step === 1'b1) n++;
      end
      chk("ramp steps", 8'(60 / (c % 4 + 3)), 8'(n));
      // Attenuation must climb one dB per step over the same window
      chk("atten rise", 8'(60 / (c % 4 + 3)), fault2_gain_atten - a0);
      rdchk(CFPS_ADDR_STICKY2, 8'h04);
      rdchk(CFPS_ADDR_STICKY2, 8'h00);
      run <= 3'h1 << (c % 3);
      tick(20);
      chk("fault2_gain_atten", 8'h00, fault2_gain_atten);
      chkf(1'b0);
    end
    // Reserved select, then detector off, with every clock stopped
    run <= 3'h0;
    for (int k = 0; k < 2; k++) begin
      wr(CFPS_ADDR_CF_CTRL, k ? 8'h00 : 8'h0d);
      tick(150);
      chkf(1'b0);
    end
    wr(CFPS_ADDR_RECOVERY, 8'h02);
    wr(CFPS_ADDR_CF_CTRL, 8'h01);
    tick(150);
    run <= 3'h1;
    tick(40);
    chkf(1'b1);
    rdchk(CFPS_ADDR_STICKY2, 8'h04);
    wr(CFPS_ADDR_CF_CTRL, 8'h00);
    tick(4);
    chkf(1'b0);
    // Detector 1 held by the inhibit bit, freed once it clears
    wr(CFPS_ADDR_RECOVERY, 8'h01);
    fault1_event <= 1'b1;
    tick(1);
    fault1_event <= 1'b0;
    fault1_clock_ok <= 1'b1;
    tick(10);
    chkf(1'b1);
    rdchk(CFPS_ADDR_STICKY2, 8'h08);
    wr(CFPS_ADDR_RECOVERY, 8'h00);
    tick(4);
    chkf(1'b0);
    wrap_up();
  end
endmodule
`default_nettype wire
